/* File: common/ccs_pkg.sv */
// Purpose: shared constants for the cascaded codec serial mode control
// Assumes: 16-bit framed serial link, two codec sections in cascade
// Notes:   control word = ctrl flag, r/w, 3-bit address, 3-bit reg, data
package ccs_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int SAMPLE_PERIOD_NS = 125000; // 8 kHz sample period
  localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  // ----------------------------------------------------------------
  // word layout
  // ----------------------------------------------------------------
  localparam int WORD_BITS = 16;
  localparam int CTRL_BIT = 15;
  localparam int ADDR_LSB = 11;
  localparam int REG_LSB = 8;
  // ----------------------------------------------------------------
  // control registers, reset value and fields
  // ----------------------------------------------------------------
  localparam logic [2:0] REG_A = 3'h0; // mode and cascade length
  localparam logic [2:0] REG_B = 3'h1; // sample and serial clock rate
  localparam logic [2:0] REG_C = 3'h2; // power control
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam int MODE_LSB = 0;         // reg A bits 1:0
  localparam int DEVCNT_LSB = 2;       // reg A bits 4:2
  localparam int ADC_PWR_BIT = 0;      // reg C
  localparam int DAC_PWR_BIT = 1;      // reg C
  localparam logic [1:0] MODE_PROGRAM = 2'h0;
  localparam logic [1:0] MODE_DATA = 2'h1;
  localparam logic [1:0] MODE_MIXED = 2'h3;
  localparam logic [15:0] INVALID_SAMPLE = 16'h0000;
  localparam int FIFO_DEPTH = 16;
endpackage

/* File: hw/ccs_top.sv */
// Purpose: serial sequencing and mode control of a two-section codec
// Assumes: serial clock sampled by ref_clk, well below half its rate
// Notes:   fifo of adc words sits between the sample timer and transmitter
// How it works
// (RQ1) after reset stay in program mode, return invalid samples, drive no dac
// (RQ2) each period return two sample words and accept two output words
// (RQ3) powered-down adc section returns an invalid word in its slot
// (RQ4) word for powered-down dac section is taken but changes nothing
// (RQ5) cascade-length field resets to 000b; host sets 001b in both
// (RQ6) write to register a moves a section to data or mixed mode
// (RQ7) host sends section 2 word before section 1, as register pairs
// (RQ8) register a and b writes land in both sections on one cycle
// (RQ9) mixed non-loopback mode takes extra control words per period
// (RQ10) host should send control words before the period's output word
// (RQ11) mixed loopback: control word uses the output slot, dac holds
// (RQ12) loopback allows one control word per section per period
// (RQ13) host shifts its pending word in on each output frame sync
// (RQ14) nonzero address: decrement and pass on instead of applying
// (RQ15) data mode counts frame syncs, loads dac at cascade length
// (RQ16) frame syncs active high, one serial clock before the msb
// (RQ17) every word is 16 bits with its own frame sync

module ccs_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);
  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("fifo depth must be a power of two, at least 2");
    end
  endgenerate
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_q, rd_q;
  logic push, pop;
  // full when pointers differ only in the wrap bit
  assign in_ready = (wr_q ^ rd_q) != {1'b1, {AW{1'b0}}};
  assign out_valid = wr_q != rd_q;
  assign out_data = mem[rd_q[AW-1:0]];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // storage
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_q[AW-1:0]] <= in_data;
    end
  end
  // pointers
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_q <= '0;
      rd_q <= '0;
    end else begin
      wr_q <= wr_q + (AW+1)'(push);
      rd_q <= rd_q + (AW+1)'(pop);
    end
  end
endmodule // ccs_fifo

module ccs_top import ccs_pkg::*; #(
  parameter int PERIOD_CYCLES = SAMPLE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic serial_clock,
  input wire logic serial_data_input,
  input wire logic input_frame_sync,
  input wire logic frame_sync_loopback,
  input wire logic [15:0] adc_sample_1,
  input wire logic [15:0] adc_sample_2,
  output logic serial_data_output,
  output logic output_frame_sync,
  output logic [15:0] dac_out_1,
  output logic [15:0] dac_out_2,
  output logic [1:0] mode_1,
  output logic [1:0] mode_2,
  output logic [7:0] rate_cfg_1,
  output logic [7:0] rate_cfg_2
);
  generate
    if (PERIOD_CYCLES < 256) begin : g_bad_period
      $error("period too short for two 16-bit words");
    end
  endgenerate
  // ----------------------------------------------------------------
  // input synchronisers and serial clock edges
  // ----------------------------------------------------------------
  logic [2:0] meta_q, sync_q;
  logic sclk_d1_q, sclk_rise, sclk_fall;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      meta_q <= 3'h0;
      sync_q <= 3'h0;
      sclk_d1_q <= 1'b0;
    end else begin
      meta_q <= {serial_clock, input_frame_sync, serial_data_input};
      sync_q <= meta_q;
      sclk_d1_q <= sync_q[2];
    end
  end
  assign sclk_rise = sync_q[2] && !sclk_d1_q;
  assign sclk_fall = !sync_q[2] && sclk_d1_q;
  // ----------------------------------------------------------------
  // receiver
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {RX_IDLE = 2'b01, RX_SHIFT = 2'b10} ccs_rx_e;
  ccs_rx_e rx_q;
  logic [3:0] rx_cnt_q;
  logic [15:0] rx_sh_q;
  logic rx_done_q;
  // sync high one bit before the msb; back-to-back frames allowed
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rx_q <= RX_IDLE;
      rx_cnt_q <= 4'h0;
      rx_sh_q <= 16'h0000;
      rx_done_q <= 1'b0;
    end else begin
      rx_done_q <= 1'b0;
      if (sclk_rise) begin
        case (rx_q)
          RX_IDLE: begin
            if (sync_q[1]) begin
              rx_q <= RX_SHIFT; // [RQ16]
              rx_cnt_q <= 4'h0;
            end
          end
          RX_SHIFT: begin
            rx_sh_q <= {rx_sh_q[14:0], sync_q[0]};
            rx_cnt_q <= rx_cnt_q + 4'h1;
            if (rx_cnt_q == 4'hF) begin
              rx_done_q <= 1'b1; // [RQ17]
              rx_q <= sync_q[1] ? RX_SHIFT : RX_IDLE;
            end
          end
          default: rx_q <= RX_IDLE;
        endcase
      end
    end
  end
  // ----------------------------------------------------------------
  // control word decode and register file of both sections
  // ----------------------------------------------------------------
  logic [7:0] regs_q [2][8]; // index 0 is section 1
  logic pend_q;
  logic [2:0] pend_reg_q;
  logic [7:0] pend_data_q;
  logic [2:0] slot_q;
  logic [15:0] dac_q [2];
  logic [1:0] mode;
  logic is_ctrl, sync_reg;
  logic [2:0] w_addr, w_reg, dev_cnt;
  logic [7:0] w_data;
  assign mode = regs_q[0][REG_A][MODE_LSB +: 2];
  assign dev_cnt = regs_q[0][REG_A][DEVCNT_LSB +: 3];
  assign w_addr = rx_sh_q[ADDR_LSB +: 3];
  assign w_reg = rx_sh_q[REG_LSB +: 3];
  assign w_data = rx_sh_q[7:0];
  // program mode takes every word as control; mixed only flagged ones
  assign is_ctrl = (mode == MODE_PROGRAM) ||
                   (mode == MODE_MIXED && rx_sh_q[CTRL_BIT]); // [RQ1] [RQ9]
  assign sync_reg = (w_reg == REG_A) || (w_reg == REG_B);
  // register writes; a/b pairs held until section 1 word arrives
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      for (int s = 0; s < 2; s++) begin
        for (int r = 0; r < 8; r++) begin
          regs_q[s][r] <= REG_RESET; // [RQ5]
        end
      end
      pend_q <= 1'b0;
      pend_reg_q <= 3'h0;
      pend_data_q <= 8'h00;
    end else if (rx_done_q && is_ctrl) begin
      if (w_addr == 3'h1) begin
        // section 1 decrements to zero, section 2 applies [RQ14]
        if (sync_reg) begin
          pend_q <= 1'b1; // [RQ7]
          pend_reg_q <= w_reg;
          pend_data_q <= w_data;
        end else begin
          regs_q[1][w_reg] <= w_data;
        end
      end else if (w_addr == 3'h0) begin
        regs_q[0][w_reg] <= w_data; // [RQ6]
        if (pend_q && pend_reg_q == w_reg) begin
          regs_q[1][pend_reg_q] <= pend_data_q; // [RQ8]
        end
        pend_q <= 1'b0;
      end
      // higher addresses leave the cascade untouched
    end
  end
  // ----------------------------------------------------------------
  // output sample slots and dac registers
  // ----------------------------------------------------------------
  logic take_slot;
  // loopback framing gives a control word the output sample's slot
  assign take_slot = rx_done_q && mode != MODE_PROGRAM &&
                     (!is_ctrl || frame_sync_loopback); // [RQ11]
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      slot_q <= 3'h0;
      dac_q[0] <= 16'h0000;
      dac_q[1] <= 16'h0000;
    end else if (take_slot) begin
      // frame sync count meets cascade length: section 1, else 2
      if (slot_q >= dev_cnt) begin
        slot_q <= 3'h0; // [RQ15]
        if (!is_ctrl && regs_q[0][REG_C][DAC_PWR_BIT]) begin
          dac_q[0] <= rx_sh_q; // [RQ4]
        end
      end else begin
        slot_q <= slot_q + 3'h1;
        if (!is_ctrl && slot_q == 3'h0 &&
            regs_q[1][REG_C][DAC_PWR_BIT]) begin
          dac_q[1] <= rx_sh_q; // [RQ4] [RQ2]
        end
      end
    end
  end
  // ----------------------------------------------------------------
  // sample timer feeding two adc words per period into the fifo
  // ----------------------------------------------------------------
  logic [$clog2(PERIOD_CYCLES)-1:0] tmr_q;
  logic [1:0] todo_q;
  logic [15:0] push_word;
  logic push_rdy, tx_valid, tx_pop;
  logic [15:0] tx_word;
  // program mode or a powered-down adc returns an invalid word
  always_comb begin
    push_word = INVALID_SAMPLE; // [RQ1]
    if (mode != MODE_PROGRAM) begin
      if (todo_q == 2'h2 && regs_q[1][REG_C][ADC_PWR_BIT]) begin
        push_word = adc_sample_2; // [RQ3]
      end else if (todo_q == 2'h1 && regs_q[0][REG_C][ADC_PWR_BIT]) begin
        push_word = adc_sample_1; // [RQ3]
      end
    end
  end
  // a full fifo stalls the pushes; words still unpushed when the period ends are dropped
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      tmr_q <= '0;
      todo_q <= 2'h0;
    end else begin
      if (tmr_q == ($clog2(PERIOD_CYCLES))'(PERIOD_CYCLES - 1)) begin
        tmr_q <= '0;
        todo_q <= 2'h2; // [RQ2]
      end else begin
        tmr_q <= tmr_q + 1'b1;
        if (todo_q != 2'h0 && push_rdy) begin
          todo_q <= todo_q - 2'h1;
        end
      end
    end
  end
  ccs_fifo #(.WIDTH(WORD_BITS), .DEPTH(FIFO_DEPTH)) i_ccs_fifo (
    .clk(ref_clk),
    .rstn(rstn),
    .in_data(push_word),
    .in_valid(todo_q != 2'h0),
    .in_ready(push_rdy),
    .out_data(tx_word),
    .out_valid(tx_valid),
    .out_ready(tx_pop)
  );
  // ----------------------------------------------------------------
  // transmitter, driven on the falling serial clock edge
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001, TX_SYNC = 3'b010, TX_SHIFT = 3'b100
  } ccs_tx_e;
  ccs_tx_e tx_q;
  logic [15:0] tx_sh_q;
  logic [3:0] tx_cnt_q;
  logic tx_bit_q, ofs_q;
  assign tx_pop = sclk_fall && tx_q == TX_IDLE && tx_valid;
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      tx_q <= TX_IDLE;
      tx_sh_q <= 16'h0000;
      tx_cnt_q <= 4'h0;
      tx_bit_q <= 1'b0;
      ofs_q <= 1'b0;
    end else if (sclk_fall) begin
      case (tx_q)
        TX_IDLE: begin
          if (tx_valid) begin
            tx_sh_q <= tx_word;
            ofs_q <= 1'b1; // [RQ16] [RQ13]
            tx_q <= TX_SYNC;
          end
        end
        TX_SYNC: begin
          ofs_q <= 1'b0;
          tx_bit_q <= tx_sh_q[15];
          tx_sh_q <= {tx_sh_q[14:0], 1'b0};
          tx_cnt_q <= 4'h1;
          tx_q <= TX_SHIFT;
        end
        TX_SHIFT: begin
          if (tx_cnt_q == 4'h0) begin
            tx_bit_q <= 1'b0; // all 16 bits sent [RQ17]
            tx_q <= TX_IDLE;
          end else begin
            tx_bit_q <= tx_sh_q[15];
            tx_sh_q <= {tx_sh_q[14:0], 1'b0};
            tx_cnt_q <= tx_cnt_q + 4'h1;
          end
        end
        default: tx_q <= TX_IDLE;
      endcase
    end
  end
  // ----------------------------------------------------------------
  // registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      serial_data_output <= 1'b0;
      output_frame_sync <= 1'b0;
      dac_out_1 <= 16'h0000;
      dac_out_2 <= 16'h0000;
      mode_1 <= MODE_PROGRAM;
      mode_2 <= MODE_PROGRAM;
      rate_cfg_1 <= REG_RESET;
      rate_cfg_2 <= REG_RESET;
    end else begin
      serial_data_output <= tx_bit_q;
      output_frame_sync <= ofs_q;
      dac_out_1 <= dac_q[0];
      dac_out_2 <= dac_q[1];
      mode_1 <= regs_q[0][REG_A][MODE_LSB +: 2];
      mode_2 <= regs_q[1][REG_A][MODE_LSB +: 2];
      rate_cfg_1 <= regs_q[0][REG_B];
      rate_cfg_2 <= regs_q[1][REG_B];
    end
  end
endmodule // ccs_top

/* File: verif/ccs_checker.sv */
// Purpose: port assertions for the codec serial mode control
// Assumes: link clock of 125 ns against a 10 ns ref_clk
// Notes: sync width figures only hold at that link rate
module ccs_checker import ccs_pkg::*; #(
  parameter int PERIOD_CYCLES = SAMPLE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic serial_clock,
  input wire logic serial_data_output,
  input wire logic output_frame_sync,
  input wire logic [15:0] dac_out_1,
  input wire logic [15:0] dac_out_2,
  input wire logic [1:0] mode_1,
  input wire logic [1:0] mode_2,
  input wire logic [7:0] rate_cfg_1,
  input wire logic [7:0] rate_cfg_2
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  logic sclk_q;
  logic ofs_q;
  logic [4:0] rise_cnt_q;
  // ----------------------------------------
  // helper: link clock rises since last sync
  // ----------------------------------------
  always_ff @(posedge ref_clk) begin
    sclk_q <= serial_clock;
    ofs_q <= output_frame_sync;
  end
  // saturates so the first sync after reset never fires
  always_ff @(posedge ref_clk) begin
    if (!rstn) begin
      rise_cnt_q <= 5'h1F;
    end else if (output_frame_sync && !ofs_q) begin
      rise_cnt_q <= 5'h00;
    end else if (serial_clock && !sclk_q && rise_cnt_q != 5'h1F) begin
      rise_cnt_q <= rise_cnt_q + 5'h01;
    end
  end
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  AST_RESET_MODE: assert property ($rose(rstn) |->
    mode_1 == MODE_PROGRAM && mode_2 == MODE_PROGRAM &&
    dac_out_1 == 16'h0000 && dac_out_2 == 16'h0000)
    else $error("outputs not idle after reset");
  AST_RESET_CFG: assert property ($rose(rstn) |->
    rate_cfg_1 == REG_RESET && rate_cfg_2 == REG_RESET)
    else $error("config not at reset value");
  AST_PROGRAM_DAC_HOLD: assert property (
    mode_1 == MODE_PROGRAM |=> $stable(dac_out_1) && $stable(dac_out_2))
    else $error("dac moved in program mode");
  AST_SYNC_WIDTH: assert property ($rose(output_frame_sync) |->
    output_frame_sync [*8] ##[1:10] !output_frame_sync)
    else $error("output sync not one link clock wide");
  AST_SYNC_SPACING: assert property (
    $rose(output_frame_sync) |-> rise_cnt_q >= 5'h10)
    else $error("output words shorter than sixteen bits");
  AST_DOUT_ON_LOW: assert property (
    $changed(serial_data_output) || $changed(output_frame_sync)
    |-> !serial_clock)
    else $error("output changed while link clock high");
  AST_RATE_TOGETHER: assert property (
    $changed(rate_cfg_1) || $changed(rate_cfg_2) |=>
    ($stable(rate_cfg_1) && $stable(rate_cfg_2)) [*8])
    else $error("rate settings updated on different cycles");
  AST_MODE_TOGETHER: assert property (
    $changed(mode_1) || $changed(mode_2) |->
    ##1 ($stable(mode_1) && $stable(mode_2)) [*8])
    else $error("mode fields updated on different cycles");
  AST_DAC_ONE_SLOT: assert property (
    $changed(dac_out_1) |-> $stable(dac_out_2))
    else $error("both dacs loaded from one word");
  cover property ($rose(output_frame_sync));
  cover property (mode_1 == MODE_MIXED ##1 $changed(dac_out_1));
  cover property (mode_1 == MODE_DATA ##1 $changed(dac_out_2));
  cover property ($changed(rate_cfg_2));
endmodule // ccs_checker

bind ccs_top ccs_checker #(.PERIOD_CYCLES(PERIOD_CYCLES)) u_ccs_checker (
  .ref_clk(ref_clk), .rstn(rstn), .serial_clock(serial_clock),
  .serial_data_output(serial_data_output),
  .output_frame_sync(output_frame_sync), .dac_out_1(dac_out_1),
  .dac_out_2(dac_out_2), .mode_1(mode_1), .mode_2(mode_2),
  .rate_cfg_1(rate_cfg_1), .rate_cfg_2(rate_cfg_2)
);

/* File: verif/ccs_host_model.sv */
// Purpose: host serial port model on the far side of the link
// Assumes: link clock made here, running free like the codec's
// Notes: a released data line shows the inverse of its last bit
module ccs_host_model import ccs_pkg::*; (
  output logic serial_clock,
  output logic serial_data_input,
  output logic host_sync,
  input wire logic frame_sync_loopback,
  input wire logic serial_data_output,
  input wire logic output_frame_sync
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] pend_2 = 16'h0000; // section 2 word, loopback framing
  logic [15:0] pend_1 = 16'h0000; // section 1 word, loopback framing
  logic [15:0] rx_sh = 16'h0000;
  logic [15:0] rx1;
  logic [15:0] rx2;
  int rx_n = 0;
  int bit_n = 0;
  // ----------------------------------------
  // link clock and transmit side
  // ----------------------------------------
  // edges kept off ref_clk edges so the synchroniser never races the pin
  initial begin
    serial_clock = 1'b0;
    serial_data_input = 1'b0;
    host_sync = 1'b0;
    #1.5;
    forever #62.5 serial_clock = ~serial_clock;
  end
  // msb first, changed on falling edges, one bit per link clock
  task automatic shift(input logic [15:0] w);
    for (int i = 15; i >= 0; i--) begin
      @(negedge serial_clock);
      host_sync = 1'b0;
      serial_data_input = w[i];
    end
  endtask
  // own framing: sync high one link clock ahead of the msb
  task automatic send(input logic [15:0] w);
    @(negedge serial_clock);
    host_sync = 1'b1;
    shift(w);
    @(negedge serial_clock);
    serial_data_input = ~w[0];
  endtask
  // loopback: one word per codec sync, so one per section
  always begin
    @(posedge serial_clock iff (frame_sync_loopback && output_frame_sync));
    // even frames carry section 2, so its word goes in first
    shift(rx_n % 2 == 0 ? pend_2 : pend_1);
  end
  // ----------------------------------------
  // receive side: even words are section 2
  // ----------------------------------------
  always @(posedge serial_clock) begin
    if (bit_n > 0) begin
      rx_sh = {rx_sh[14:0], serial_data_output};
      bit_n--;
      if (bit_n == 0) begin
        if (rx_n % 2 == 0) rx2 = rx_sh;
        else rx1 = rx_sh;
        rx_n++;
      end
    end
    if (output_frame_sync) bit_n = 16;
  end
endmodule // ccs_host_model

/* File: verif/ccs_top_bench.sv */
// Purpose: self-checking bench for the codec serial mode control
// Assumes: 100 MHz ref_clk, host model makes a 125 ns link clock
// Notes: a short sample period keeps the run brief
module ccs_top_bench import ccs_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int PER = 1000;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic lb = 1'b0;
  logic [15:0] adc1 = 16'h0000;
  logic [15:0] adc2 = 16'h0000;
  logic sclk, ser_in, hfs, ser_out, ofs;
  logic [15:0] dac1, dac2, a, b;
  logic [1:0] m1, m2;
  logic [7:0] r1, r2, d;
  int fails = 0;
  int checks = 0;
  always #5 ref_clk = ~ref_clk;
  ccs_top #(.PERIOD_CYCLES(PER)) i_ccs_top (
    .ref_clk(ref_clk), .rstn(rstn), .serial_clock(sclk),
    .serial_data_input(ser_in), .input_frame_sync(lb ? ofs : hfs),
    .frame_sync_loopback(lb), .adc_sample_1(adc1), .adc_sample_2(adc2),
    .serial_data_output(ser_out), .output_frame_sync(ofs),
    .dac_out_1(dac1), .dac_out_2(dac2), .mode_1(m1), .mode_2(m2),
    .rate_cfg_1(r1), .rate_cfg_2(r2));
  ccs_host_model host (.serial_clock(sclk), .serial_data_input(ser_in),
    .host_sync(hfs), .frame_sync_loopback(lb),
    .serial_data_output(ser_out), .output_frame_sync(ofs));
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic chk(input string nm, input logic [15:0] got,
                     input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // control word: flag, r/w clear, address, register, data
  function automatic logic [15:0] cw(input logic [2:0] ad,
      input logic [2:0] rg, input logic [7:0] dt);
    return {1'b1, 1'b0, ad, rg, dt};
  endfunction
  // section 2 first so a and b writes update both sections together
  task automatic wr(input logic [2:0] rg, input logic [7:0] dt);
    host.send(cw(3'h1, rg, dt));
    host.send(cw(3'h0, rg, dt));
    tick(8);
  endtask
  task automatic dac_pair(input logic [15:0] w2, input logic [15:0] w1);
    host.send(w2);
    host.send(w1);
    tick(8);
  endtask
  // waits long enough for the fifo to hold only fresh samples
  task automatic adc_chk(input logic [15:0] e2, input logic [15:0] e1);
    tick(3 * PER);
    chk("adc_2", host.rx2, e2);
    chk("adc_1", host.rx1, e1);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // hang guard, well above the expected run
  initial begin
    repeat (60000) @(posedge ref_clk);
    fails++;
    tally_and_finish;
  end
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    void'($urandom(64));
    tick(20);
    rstn = 1'b1;
    tick(3);
    chk("mode_1", m1, MODE_PROGRAM);
    chk("mode_2", m2, MODE_PROGRAM);
    chk("rate_cfg_2", r2, REG_RESET);
    adc1 = 16'($urandom);
    adc2 = 16'($urandom);
    adc_chk(INVALID_SAMPLE, INVALID_SAMPLE);
    chk("dac_out_1", dac1, 16'h0000);
    $display("reset test done");
    d = 8'($urandom);
    wr(REG_B, d);
    chk("rate_cfg_2", r2, d);
    chk("rate_cfg_1", r1, d);
    wr(REG_C, 8'h03);
    wr(REG_A, {3'h0, 3'h1, MODE_MIXED});
    chk("mode_1", m1, MODE_MIXED);
    chk("mode_2", m2, MODE_MIXED);
    // control words ahead of each dac pair, not aligned to a sample period
    repeat (3) begin
      d = 8'($urandom);
      a = 16'($urandom) & 16'h7FFF;
      b = 16'($urandom) & 16'h7FFF;
      wr(REG_B, d);
      dac_pair(a, b);
      chk("rate_cfg_2", r2, d);
      chk("dac_out_2", dac2, a);
      chk("dac_out_1", dac1, b);
    end
    adc_chk(adc2, adc1);
    $display("mixed test done");
    wr(REG_C, 8'h00);
    dac_pair(a ^ 16'h0F0F, b ^ 16'h0F0F);
    chk("dac_out_2", dac2, a);
    chk("dac_out_1", dac1, b);
    adc_chk(INVALID_SAMPLE, INVALID_SAMPLE);
    wr(REG_C, 8'h03);
    $display("power down test done");
    d = 8'($urandom);
    host.pend_2 = cw(3'h1, REG_B, d);
    host.pend_1 = cw(3'h0, REG_B, d);
    // framing switches only at a pair start, so slots stay paired
    @(posedge ofs iff host.rx_n % 2 == 0);
    #1;
    lb = 1'b1;
    tick(2 * PER);
    @(posedge ofs iff host.rx_n % 2 == 0);
    #1;
    lb = 1'b0;
    tick(8);
    chk("rate_cfg_1", r1, d);
    chk("rate_cfg_2", r2, d);
    chk("dac_out_2", dac2, a);
    chk("dac_out_1", dac1, b);
    $display("loopback test done");
    wr(REG_A, {3'h0, 3'h1, MODE_DATA});
    chk("mode_1", m1, MODE_DATA);
    chk("mode_2", m2, MODE_DATA);
    repeat (4) begin
      a = 16'($urandom);
      b = 16'($urandom);
      adc1 = 16'($urandom);
      adc2 = 16'($urandom);
      dac_pair(a, b);
      chk("dac_out_2", dac2, a);
      chk("dac_out_1", dac1, b);
    end
    adc_chk(adc2, adc1);
    $display("data test done");
    tally_and_finish;
  end
endmodule // ccs_top_bench
